/* rtl/timer_status_control.sv */
// design: module-wide status and control register of a multi-channel timer
// What this block does
// R1: the overflow flag (bit 7) sets when the counter wraps to zero after reaching the modulo.
// R2: the flag clears only by reading the register with the flag set, then writing zero to it.
// R3: an overflow between that read and the zero-write drops the armed sequence so the flag stays set.
// R4: writing one to the flag position leaves the flag unchanged.
// R5: reset clears the flag, the interrupt enable and the center-aligned select.
// R6: bit 6 enables an interrupt request while the flag is set; zero means polling.
// R7: bit 5 set makes the counter count up/down with all channels in center-aligned mode.
// R8: bit 5 clear makes the counter count up only, channels choosing their own function.
// R9: clock source 00 feeds no clock to the prescaler, disabling the counter.
// R10: clock source 01 feeds the bus clock, 10 the fixed-frequency clock.
// R11: clock source 11 has no clock and software should not select it.
// R12: the settings in this register apply jointly to all channels.
// R13: prescale field divides by two to its value (1..128) and acts on the next bus clock.
// R14: any write to this register with byte lane 0 enabled restarts the coherent counter read latch.
// R15: the unavailable clock encoding is treated as no clock and holds the counter.
//
// Design decision made here: the Avalon-MM register port.
`timescale 1ns/10ps
`default_nettype none
module timer_status_control
  import timer_status_control_pkg::*;
#(
  parameter int PRESCALE_W = PRESCALE_CNT_W
) (
  input wire logic I_MCLK,
  input wire logic I_RSTN,
  // avalon-mm slave
  input wire logic [ADDR_W-1:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [3:0] i_byteenable,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  // timer core connections
  input wire logic i_counter_wrap,
  input wire logic i_fixed_clk,
  output logic o_count_tick,
  output logic o_up_down_mode,
  output logic o_channel_own_mode,
  output logic o_read_latch_restart,
  output logic o_ovf_irq_request,
  output logic o_irq
);

  // ------------------------------------------------------------
  // types and helpers
  // ------------------------------------------------------------

  // progress of the two-step flag clearing sequence
  typedef enum logic [0:0] {
    CLR_IDLE = 1'b0,
    CLR_ARMED = 1'b1
  } clr_state_t;

  // register select by byte address
  function automatic logic addr_hit(
    input logic [ADDR_W-1:0] addr,
    input logic [ADDR_W-1:0] offset
  );
    return addr == offset;
  endfunction

  // a write only counts when byte lane 0 is enabled
  function automatic logic lane0_write(
    input logic wr,
    input logic hit,
    input logic [3:0] be
  );
    return wr && hit && be[0];
  endfunction

  // low-bit mask of the prescale counter: divide by two to the field value
  function automatic logic [PRESCALE_W-1:0] prescale_mask(
    input logic [PRESCALE_HI:PRESCALE_LO] ps
  );
    return PRESCALE_W'((1 << ps) - 1);
  endfunction

  // 8-bit registers sit in the low byte, upper bits read zero
  function automatic logic [31:0] pack_byte(
    input logic [7:0] value
  );
    return {24'h000000, value};
  endfunction

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------

  // control fields shared by all channels
  ctrl_t ctrl;
  ctrl_t next_ctrl;

  // overflow flag and its clearing sequence
  logic overflow_flag;
  clr_state_t clr_state;
  clr_state_t next_clr_state;

  // interrupt status and mask
  logic [EVT_W-1:0] irq_status;
  logic [EVT_W-1:0] irq_mask;

  // fixed clock: two synchroniser stages, then one stage for edge detection
  logic fixed_s1;
  logic fixed_s2;
  logic fixed_s3;

  // prescaler
  logic [PRESCALE_W-1:0] prescale_cnt;
  logic count_tick;

  // read handshake
  logic read_ack;

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------

  wire logic sel_sc = addr_hit(i_address, SC_OFFSET);
  wire logic sel_status = addr_hit(i_address, IRQ_STATUS_OFFSET);
  wire logic sel_mask = addr_hit(i_address, IRQ_MASK_OFFSET);
  wire logic wr_sc = lane0_write(i_write, sel_sc, i_byteenable);
  wire logic wr_status = lane0_write(i_write, sel_status, i_byteenable);
  wire logic wr_mask = lane0_write(i_write, sel_mask, i_byteenable);
  wire logic read_first = i_read && !read_ack;
  wire logic rd_sc = i_read && sel_sc && read_ack;

  // writes finish in one cycle, reads need one wait cycle for registered data
  assign o_waitrequest = read_first;

  wire logic [7:0] sc_value = {overflow_flag, ctrl};
  wire logic [31:0] next_readdata = sel_sc ? pack_byte(sc_value) :
                                    sel_status ? pack_byte(8'(irq_status)) :
                                    sel_mask ? pack_byte(8'(irq_mask)) : BUS_ZERO;

  // ------------------------------------------------------------
  // control fields
  // ------------------------------------------------------------

  wire logic [IRQ_EN_BIT:PRESCALE_LO] ctrl_bits = i_writedata[IRQ_EN_BIT:PRESCALE_LO] &
                                                  WRITABLE_MASK[IRQ_EN_BIT:PRESCALE_LO];
  assign next_ctrl = wr_sc ? ctrl_t'(ctrl_bits) : ctrl; // R12 R13

  // ------------------------------------------------------------
  // overflow flag and clearing sequence
  // ------------------------------------------------------------

  wire logic flag_zero_write = wr_sc && !i_writedata[OVF_BIT] && (clr_state == CLR_ARMED);
  wire logic next_overflow_flag = i_counter_wrap ? 1'b1 : // R1 R3
                                  flag_zero_write ? 1'b0 : overflow_flag; // R2 R4

  // a wrap always drops the armed state, so a late overflow survives the zero-write
  always_comb begin
    next_clr_state = clr_state;
    unique case (clr_state)
      CLR_IDLE: begin
        if (rd_sc && overflow_flag && !i_counter_wrap) begin
          next_clr_state = CLR_ARMED; // R2
        end
      end
      CLR_ARMED: begin
        if (i_counter_wrap || wr_sc) begin
          next_clr_state = CLR_IDLE; // R3
        end
      end
    endcase
  end

  // ------------------------------------------------------------
  // clock selection and prescaler
  // ------------------------------------------------------------

  wire logic fixed_rise = fixed_s2 && !fixed_s3;
  wire logic src_pulse = (ctrl.clock_source == CLK_BUS) ? 1'b1 : // R10
                         (ctrl.clock_source == CLK_FIXED) ? fixed_rise : // R10
                         1'b0; // R9 R11 R15
  wire logic [PRESCALE_W-1:0] div_mask = prescale_mask(ctrl.prescale); // R13
  wire logic next_count_tick = src_pulse && ((prescale_cnt & div_mask) == '0);
  wire logic [PRESCALE_W-1:0] next_prescale_cnt = src_pulse ?
                                PRESCALE_W'(prescale_cnt + 1'b1) : prescale_cnt;

  // ------------------------------------------------------------
  // interrupt status
  // ------------------------------------------------------------

  // a new event wins over a clear in the same cycle
  wire logic [EVT_W-1:0] clear_bits = wr_status ? i_writedata[EVT_W-1:0] : '0;
  wire logic [EVT_W-1:0] next_irq_status = (irq_status & ~clear_bits) |
                                           {EVT_W{i_counter_wrap}};

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------

  // control fields
  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      ctrl <= CTRL_RESET; // R5
    end else begin
      ctrl <= next_ctrl;
    end
  end

  // overflow flag
  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      overflow_flag <= 1'b0; // R5
    end else begin
      overflow_flag <= next_overflow_flag;
    end
  end

  // clearing sequence
  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      clr_state <= CLR_IDLE;
    end else begin
      clr_state <= next_clr_state;
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      irq_status <= '0;
    end else begin
      irq_status <= next_irq_status;
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      irq_mask <= '0;
    end else if (wr_mask) begin
      irq_mask <= i_writedata[EVT_W-1:0];
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      read_ack <= 1'b0;
    end else begin
      read_ack <= read_first;
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      o_readdata <= BUS_ZERO;
    end else if (read_first) begin
      o_readdata <= next_readdata;
    end
  end

  // only the second stage is read by logic
  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      fixed_s1 <= 1'b0;
      fixed_s2 <= 1'b0;
    end else begin
      fixed_s1 <= i_fixed_clk;
      fixed_s2 <= fixed_s1;
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      fixed_s3 <= 1'b0;
    end else begin
      fixed_s3 <= fixed_s2;
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      prescale_cnt <= '0;
    end else begin
      prescale_cnt <= next_prescale_cnt;
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      count_tick <= 1'b0;
    end else begin
      count_tick <= next_count_tick;
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      o_read_latch_restart <= 1'b0;
    end else begin
      o_read_latch_restart <= wr_sc; // R14
    end
  end

  // ------------------------------------------------------------
  // outputs to the timer core
  // ------------------------------------------------------------

  assign o_count_tick = count_tick;
  assign o_up_down_mode = ctrl.center_align_select; // R7 R12
  assign o_channel_own_mode = !ctrl.center_align_select; // R8
  assign o_ovf_irq_request = overflow_flag && ctrl.overflow_irq_enable; // R6
  assign o_irq = |(irq_status & irq_mask) || o_ovf_irq_request;

endmodule
`default_nettype wire

/* rtl/timer_status_control_pkg.sv */
// package: register map, field layout and types of the timer status/control block
package timer_status_control_pkg;
  // register word offsets (byte addresses)
  localparam logic [3:0] SC_OFFSET = 4'h0;
  localparam logic [3:0] IRQ_STATUS_OFFSET = 4'h4;
  localparam logic [3:0] IRQ_MASK_OFFSET = 4'h8;
  localparam int ADDR_W = 4;
  // status/control field positions
  localparam int OVF_BIT = 7;
  localparam int IRQ_EN_BIT = 6;
  localparam int CENTER_BIT = 5;
  localparam int CLKSRC_HI = 4;
  localparam int CLKSRC_LO = 3;
  localparam int PRESCALE_HI = 2;
  localparam int PRESCALE_LO = 0;
  localparam logic [7:0] SC_RESET = 8'h00;
  localparam logic [7:0] WRITABLE_MASK = 8'h7F;
  // interrupt status/mask bit positions
  localparam int EVT_OVF = 0;
  localparam int EVT_W = 1;
  localparam int PRESCALE_CNT_W = 7;
  localparam logic [31:0] BUS_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {
    CLK_NONE = 2'b00,
    CLK_BUS = 2'b01,
    CLK_FIXED = 2'b10,
    CLK_UNAVAIL = 2'b11
  } clk_src_t;

  typedef struct packed {
    logic overflow_irq_enable;
    logic center_align_select;
    clk_src_t clock_source;
    logic [2:0] prescale;
  } ctrl_t;

  localparam ctrl_t CTRL_RESET = '{1'b0, 1'b0, CLK_NONE, 3'b000};
endpackage

/* bench/timer_status_control_monitor.sv */
// checker: port-level properties of the timer status/control block
`timescale 1ns/10ps
`default_nettype none
module timer_status_control_monitor
  import timer_status_control_pkg::*;
(
  input wire logic I_MCLK,
  input wire logic I_RSTN,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic i_counter_wrap,
  input wire logic [ADDR_W-1:0] i_address,
  input wire logic [31:0] i_writedata,
  input wire logic o_waitrequest,
  input wire logic o_up_down_mode,
  input wire logic o_channel_own_mode,
  input wire logic o_read_latch_restart,
  input wire logic o_ovf_irq_request,
  input wire logic o_irq
);
  default clocking @(posedge I_MCLK); endclocking
  default disable iff (!I_RSTN);
  wire logic sc_wr = i_write && i_address == SC_OFFSET;
  mode_pair_a: assert property (o_channel_own_mode != o_up_down_mode)
    else $error("mode outputs not inverse");
  latch_restart_a: assert property (sc_wr |=> o_read_latch_restart)
    else $error("no latch restart");
  restart_cause_a: assert property (o_read_latch_restart |-> $past(sc_wr))
    else $error("stray latch restart");
  read_wait_a: assert property ($rose(i_read) |-> o_waitrequest ##1 !o_waitrequest)
    else $error("read wait wrong");
  irq_follow_a: assert property (o_ovf_irq_request |-> o_irq)
    else $error("irq missing");
  irq_off_a: assert property (sc_wr && !i_writedata[IRQ_EN_BIT] |=> !o_ovf_irq_request)
    else $error("irq not disabled");
  flag_hold_a: assert property (o_ovf_irq_request && !sc_wr |=> o_ovf_irq_request)
    else $error("flag lost");
  flag_cause_a: assert property ($rose(o_ovf_irq_request) |-> $past(i_counter_wrap || sc_wr))
    else $error("flag without cause");
endmodule
`default_nettype wire

/* bench/test_timer_status_control.sv */
// testbench: bus-level tests of the timer status/control block
`timescale 1ns/10ps
`default_nettype none
module test_timer_status_control;
  import timer_status_control_pkg::*;
  logic clk = 0, rstn = 0, rd_s = 0, wr_s = 0, wrap = 0, fix = 0;
  logic [ADDR_W-1:0] adr = '0;
  logic [31:0] wd = '0, rdv, rdata;
  logic o_wait, tick, updn, own, rst_l, ovf, irq;
  int err_total = 0, checked = 0, ticks = 0, cyc = 0;
  timer_status_control dut (.I_MCLK(clk), .I_RSTN(rstn), .i_address(adr), .i_read(rd_s),
    .i_write(wr_s), .i_writedata(wd), .i_byteenable(4'hF), .o_readdata(rdata),
    .o_waitrequest(o_wait), .i_counter_wrap(wrap), .i_fixed_clk(fix), .o_count_tick(tick),
    .o_up_down_mode(updn), .o_channel_own_mode(own), .o_read_latch_restart(rst_l),
    .o_ovf_irq_request(ovf), .o_irq(irq));
  // fixed clock: rising edge every 8 bus clocks
  always @(posedge clk) begin
    cyc <= cyc + 1;
    fix <= cyc[2];
    if (tick === 1'b1) ticks <= ticks + 1;
  end
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic bus(logic w, logic [3:0] a, logic [31:0] d);
    @(posedge clk);
    adr <= a;
    wd <= d;
    wr_s <= w;
    rd_s <= !w;
    do @(posedge clk); while (o_wait !== 1'b0);
    rdv = rdata;
    wr_s <= 0;
    rd_s <= 0;
    #1;
  endtask
  task automatic rd(logic [3:0] a, logic [31:0] e, string n);
    bus(0, a, 32'h0);
    chk(n, e, rdv);
  endtask
  task automatic pulse;
    @(posedge clk);
    wrap <= 1;
    @(posedge clk);
    wrap <= 0;
    #1;
  endtask
  task automatic tick_cnt(logic [7:0] sc, int e);
    int t0;
    bus(1, SC_OFFSET, {24'h0, sc});
    repeat (16) @(posedge clk);
    t0 = ticks;
    repeat (256) @(posedge clk);
    chk("ticks", e, ticks - t0);
  endtask
  task automatic close_out;
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial forever #4 clk = ~clk;
  initial begin
    #200000;
    err_total++;
    close_out;
  end
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1;
    rd(SC_OFFSET, 32'h0, "sc reset");
    rd(4'hC, 32'h0, "unmapped");
    bus(1, SC_OFFSET, 32'hFF);
    rd(SC_OFFSET, 32'h7F, "sc write");
    chk("up down", 1, updn);
    bus(1, SC_OFFSET, 32'h48);
    chk("own mode", 1, own);
    pulse();
    rd(SC_OFFSET, 32'hC8, "flag set");
    chk("ovf irq", 1, ovf);
    bus(1, SC_OFFSET, 32'hC8);
    bus(1, SC_OFFSET, 32'h48);
    rd(SC_OFFSET, 32'hC8, "unarmed clear");
    pulse();
    bus(1, SC_OFFSET, 32'h48);
    rd(SC_OFFSET, 32'hC8, "wrap in clear");
    bus(1, SC_OFFSET, 32'h48);
    rd(SC_OFFSET, 32'h48, "flag clear");
    chk("ovf irq", 0, ovf);
    rd(IRQ_STATUS_OFFSET, 32'h1, "irq status");
    chk("irq masked", 0, irq);
    bus(1, IRQ_MASK_OFFSET, 32'h1);
    chk("irq unmasked", 1, irq);
    bus(1, IRQ_STATUS_OFFSET, 32'h1);
    rd(IRQ_STATUS_OFFSET, 32'h0, "irq cleared");
    chk("irq low", 0, irq);
    bus(1, SC_OFFSET, 32'h68);
    pulse();
    bus(1, SC_OFFSET, 32'h28);
    chk("ovf irq off", 0, ovf);
    rd(SC_OFFSET, 32'hA8, "flag polled");
    rstn <= 0;
    repeat (2) @(posedge clk);
    rstn <= 1;
    rd(SC_OFFSET, 32'h0, "sc mid reset");
    chk("irq reset", 0, irq);
    for (int p = 0; p < 8; p++) tick_cnt(8'h08 | p[7:0], 256 >> p);
    tick_cnt(8'h00, 0);
    tick_cnt(8'h18, 0);
    tick_cnt(8'h10, 32);
    tick_cnt(8'h11, 16);
    close_out();
  end
endmodule
bind timer_status_control timer_status_control_monitor mon (.*);
`default_nettype wire
